// ==== irq_level_pkg.sv ====
// Constants, carrier type and state enum for the interrupt level selector.
// Assumes a 32-bit APB bus and a core that takes vectored, leveled requests.
package irq_level_pkg;
    localparam int NUM_SRC = 9;
    localparam int LVL_W = 3;
    localparam int VEC_W = 8;
    localparam int IDX_W = 16;
    localparam int EV_W = 2;
    // Register indexes; byte address is four times the index
    localparam logic [15:0] IDX_TIMER8 = 16'h430E;
    localparam logic [15:0] IDX_T16 = 16'h4310;
    localparam logic [15:0] IDX_SERIAL = 16'h4312;
    localparam logic [15:0] IDX_SPI_I2C = 16'h4314;
    localparam logic [15:0] IDX_REMOTE = 16'h4316;
    localparam logic [15:0] IDX_STATUS = 16'h4318;
    localparam logic [15:0] IDX_MASK = 16'h431A;
    localparam logic [15:0] IDX_STEP = 16'h0002;
    localparam int NUM_PAIRS = 4;
    localparam int LO_POS = 0;
    localparam int HI_POS = 8;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam int EV_ACCEPT = 0;
    localparam int EV_PREEMPT = 1;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    localparam logic [3:0] SRC_RESET = 4'h0;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] vector;
        logic [2:0] level;
    } core_req_s;

    typedef enum logic [1:0] {ST_IDLE, ST_PRESENT, ST_SETTLE} present_state_e;
endpackage

// ==== interrupt_level_setup.sv ====
// Interrupt level setup and priority selector with an APB register port.
// Assumes pending/enable flags come from flag logic on pclk, and the core
// answers a presented request with a one-cycle core_ack on pclk.
// Notes on behaviour
// - Timer8 level field low bits, reset zero
// - Timer16 ch1 low, ch2 high fields
// - Serial0 low, serial1 high level fields
// - SPI low, I2C high level fields
// - Remote receiver low, pwm ch1 high fields
// - Reserved bits read zero, writes ignored
// - Highest configured level is presented first
// - Equal levels: lowest vector number wins
// - Higher newcomer replaces unaccepted presented request
`timescale 1ns/1ps
module interrupt_level_setup #(
    parameter logic [7:0] VEC_BASE = 8'h10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [irq_level_pkg::NUM_SRC-1:0] src_pending,
    input wire logic [irq_level_pkg::NUM_SRC-1:0] src_enable,
    input wire logic core_ack,
    output logic core_req,
    output irq_level_pkg::core_req_s core_sel,
    output logic irq
);
    // Refused at elaboration: vectors past 0xFF would wrap onto low numbers
    if (int'(VEC_BASE) + irq_level_pkg::NUM_SRC > 256) begin : bad_vec_base
        $error("VEC_BASE leaves no room for all vectors");
    end

    // Higher level wins; on a tie the lower source index, hence lower vector
    function automatic logic beats(input logic [2:0] la, input logic [3:0] ia,
                                   input logic [2:0] lb, input logic [3:0] ib);
        beats = (la > lb) || ((la == lb) && (ia < ib));
    endfunction

    function automatic logic [15:0] pair_idx(input int k);
        pair_idx = irq_level_pkg::IDX_T16 + 16'(k) * irq_level_pkg::IDX_STEP;
    endfunction

    logic [2:0] lvl_reg [irq_level_pkg::NUM_SRC];
    logic [2:0] lvl_next [irq_level_pkg::NUM_SRC];
    logic [1:0] status_reg, status_next, mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    irq_level_pkg::present_state_e state_reg, state_next;
    logic [3:0] cur_reg, cur_next;
    irq_level_pkg::core_req_s sel_reg, sel_next;
    logic req_reg, req_next;

    logic [irq_level_pkg::NUM_SRC-1:0] active;
    logic found;
    logic [3:0] best_idx;
    logic [2:0] best_lvl;
    logic [1:0] ev;
    logic apb_go, wr_fire, hit;
    logic [15:0] idx;
    logic [31:0] rd_val;
    logic outranked;

    assign idx = paddr[17:2];
    assign hit = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0) &&
                 (idx == irq_level_pkg::IDX_TIMER8 || idx == irq_level_pkg::IDX_T16 ||
                  idx == irq_level_pkg::IDX_SERIAL || idx == irq_level_pkg::IDX_SPI_I2C ||
                  idx == irq_level_pkg::IDX_REMOTE || idx == irq_level_pkg::IDX_STATUS ||
                  idx == irq_level_pkg::IDX_MASK);
    // One wait state: pready rises the cycle after the access phase starts
    assign apb_go = psel && penable && !pready_reg;
    assign wr_fire = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign active = src_pending & src_enable;

    always_comb begin
        rd_val = irq_level_pkg::DATA_RESET;
        if (idx == irq_level_pkg::IDX_TIMER8) begin
            rd_val[irq_level_pkg::LO_POS +: 3] = lvl_reg[0];
        end
        for (int k = 0; k < irq_level_pkg::NUM_PAIRS; k++) begin
            if (idx == pair_idx(k)) begin
                rd_val[irq_level_pkg::LO_POS +: 3] = lvl_reg[1 + 2 * k];
                rd_val[irq_level_pkg::HI_POS +: 3] = lvl_reg[2 + 2 * k];
            end
        end
        if (idx == irq_level_pkg::IDX_STATUS) begin
            rd_val[1:0] = status_reg;
        end
        if (idx == irq_level_pkg::IDX_MASK) begin
            rd_val[1:0] = mask_reg;
        end
        // Everything not filled above, reserved bits included, reads zero
    end

    always_comb begin
        pready_next = apb_go;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (apb_go) begin
            prdata_next = hit ? rd_val : irq_level_pkg::DATA_RESET;
            pslverr_next = !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= irq_level_pkg::DATA_RESET;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    always_comb begin
        for (int i = 0; i < irq_level_pkg::NUM_SRC; i++) begin
            lvl_next[i] = lvl_reg[i];
        end
        mask_next = mask_reg;
        status_next = status_reg;
        if (wr_fire) begin
            // Only the 3-bit level fields and the 2-bit mask and status fields take data; reserved positions are dropped
            if (idx == irq_level_pkg::IDX_TIMER8) begin
                lvl_next[0] = pwdata[irq_level_pkg::LO_POS +: 3];
            end
            for (int k = 0; k < irq_level_pkg::NUM_PAIRS; k++) begin
                if (idx == pair_idx(k)) begin
                    lvl_next[1 + 2 * k] = pwdata[irq_level_pkg::LO_POS +: 3];
                    lvl_next[2 + 2 * k] = pwdata[irq_level_pkg::HI_POS +: 3];
                end
            end
            if (idx == irq_level_pkg::IDX_MASK) begin
                mask_next = pwdata[1:0];
            end
            if (idx == irq_level_pkg::IDX_STATUS) begin
                status_next = status_reg & ~pwdata[1:0];
            end
        end
        // A new event outranks a clear written in the same cycle
        status_next = status_next | ev;
        irq_next = |(status_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < irq_level_pkg::NUM_SRC; i++) begin
                lvl_reg[i] <= irq_level_pkg::LEVEL_RESET;
            end
            status_reg <= irq_level_pkg::STATUS_RESET;
            mask_reg <= irq_level_pkg::MASK_RESET;
            irq_reg <= 1'b0;
        end else begin
            for (int i = 0; i < irq_level_pkg::NUM_SRC; i++) begin
                lvl_reg[i] <= lvl_next[i];
            end
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    // Scan upward and take only a strictly higher level, so ties keep the lowest index
    always_comb begin
        found = 1'b0;
        best_idx = irq_level_pkg::SRC_RESET;
        best_lvl = irq_level_pkg::LEVEL_RESET;
        for (int i = 0; i < irq_level_pkg::NUM_SRC; i++) begin
            if (active[i] && (!found || lvl_reg[i] > best_lvl)) begin
                found = 1'b1;
                best_idx = 4'(i);
                best_lvl = lvl_reg[i];
            end
        end
    end

    // Second opinion on the scan, read only by the highest-level check below
    always_comb begin
        outranked = 1'b0;
        for (int i = 0; i < irq_level_pkg::NUM_SRC; i++) begin
            if (active[i] && (lvl_reg[i] > best_lvl ||
                              (lvl_reg[i] == best_lvl && 4'(i) < best_idx))) begin
                outranked = 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        cur_next = cur_reg;
        sel_next = sel_reg;
        req_next = req_reg;
        ev = 2'h0;
        case (state_reg)
            irq_level_pkg::ST_IDLE: begin
                if (found) begin
                    state_next = irq_level_pkg::ST_PRESENT;
                    cur_next = best_idx;
                    sel_next.vector = VEC_BASE + 8'(best_idx);
                    sel_next.level = best_lvl;
                    req_next = 1'b1;
                end
            end
            irq_level_pkg::ST_PRESENT: begin
                if (core_ack) begin
                    state_next = irq_level_pkg::ST_SETTLE;
                    req_next = 1'b0;
                    ev[irq_level_pkg::EV_ACCEPT] = 1'b1;
                end else if (!active[cur_reg]) begin
                    // Source withdrew before acceptance: choose again or go quiet
                    state_next = found ? irq_level_pkg::ST_PRESENT : irq_level_pkg::ST_IDLE;
                    cur_next = best_idx;
                    sel_next.vector = VEC_BASE + 8'(best_idx);
                    sel_next.level = best_lvl;
                    req_next = found;
                end else if (found && best_idx != cur_reg &&
                             beats(best_lvl, best_idx, sel_reg.level, cur_reg)) begin
                    // Earlier source stays pending in the flag logic
                    cur_next = best_idx;
                    sel_next.vector = VEC_BASE + 8'(best_idx);
                    sel_next.level = best_lvl;
                    ev[irq_level_pkg::EV_PREEMPT] = 1'b1;
                end
            end
            irq_level_pkg::ST_SETTLE: begin
                // One idle cycle lets the handler's flag clear land
                state_next = irq_level_pkg::ST_IDLE;
            end
            default: begin
                state_next = irq_level_pkg::ST_IDLE;
                req_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= irq_level_pkg::ST_IDLE;
            cur_reg <= irq_level_pkg::SRC_RESET;
            sel_reg <= '{vector: irq_level_pkg::VECTOR_RESET, level: irq_level_pkg::LEVEL_RESET};
            req_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cur_reg <= cur_next;
            sel_reg <= sel_next;
            req_reg <= req_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign core_req = req_reg;
    assign core_sel = sel_reg;
    assign irq = irq_reg;

    chk_timer8_field: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == irq_level_pkg::IDX_TIMER8 |=> lvl_reg[0] == $past(pwdata[2:0]))
        else $error("timer8 level not written");

    chk_timer16_fields: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == irq_level_pkg::IDX_T16
        |=> lvl_reg[1] == $past(pwdata[2:0]) && lvl_reg[2] == $past(pwdata[10:8]))
        else $error("timer16 level fields wrong");

    chk_serial_fields: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == irq_level_pkg::IDX_SERIAL
        |=> lvl_reg[3] == $past(pwdata[2:0]) && lvl_reg[4] == $past(pwdata[10:8]))
        else $error("serial level fields wrong");

    chk_spi_i2c_fields: assert property (@(posedge pclk) disable iff (!presetn)
        wr_fire && idx == irq_level_pkg::IDX_SPI_I2C
        |=> lvl_reg[5] == $past(pwdata[2:0]) && lvl_reg[6] == $past(pwdata[10:8]))
        else $error("spi or i2c level fields wrong");

    chk_remote_fields: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && !pslverr && idx == irq_level_pkg::IDX_REMOTE
        |-> prdata[2:0] == lvl_reg[7] && prdata[10:8] == lvl_reg[8])
        else $error("remote or pwm level readback wrong");

    chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:11] == 21'h000000 && prdata[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    chk_highest_level: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == irq_level_pkg::ST_IDLE && found
        |-> !outranked ##1 (core_req && core_sel.level == $past(best_lvl)))
        else $error("presented level is not the highest");

    chk_tie_vector: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == irq_level_pkg::ST_IDLE && found
        |=> core_sel.vector == VEC_BASE + 8'($past(best_idx)))
        else $error("presented vector is not the lowest of its level");

    chk_preempt_swap: assert property (@(posedge pclk) disable iff (!presetn)
        core_req && !core_ack && active[cur_reg] && found &&
        best_lvl > core_sel.level |=> core_req && core_sel.level == $past(best_lvl))
        else $error("higher source did not replace presented one");

    chk_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
        core_req && !core_ack && active[cur_reg] &&
        !(found && beats(best_lvl, best_idx, core_sel.level, cur_reg))
        |=> core_req && $stable(core_sel))
        else $error("request changed before acceptance");

    chk_ack_drop: assert property (@(posedge pclk) disable iff (!presetn)
        core_req && core_ack |=> !core_req ##1 1'b1)
        else $error("request stayed up after acceptance");
endmodule

// ==== core_model.sv ====
// Behavioural processor core taking leveled, vectored interrupt requests.
// Assumes the pclk domain; acceptance is a one-cycle core_ack after a set wait.
`timescale 1ns/1ps
module core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_req,
    input wire irq_level_pkg::core_req_s core_sel,
    input wire logic accept_en,
    input wire logic [3:0] ack_wait,
    output logic core_ack
);
    logic [3:0] cnt;
    // A stalled core (accept_en low) lets the selector swap what it presents
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            core_ack <= 1'b0;
        end else begin
            core_ack <= 1'b0;
            if (core_req && !core_ack && accept_en) begin
                if (cnt == ack_wait) begin
                    core_ack <= 1'b1;
                    cnt <= 4'h0;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end else begin
                cnt <= 4'h0;
            end
        end
    end
endmodule

// ==== interrupt_level_setup_bench.sv ====
// Self-checking bench: APB register access, priority order, preemption, event irq.
// Assumes core_model stands in for the core; the bench plays the flag logic.
`timescale 1ns/1ps
module interrupt_level_setup_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [8:0] src_pending = 9'h000;
    logic [8:0] src_enable = 9'h000;
    logic core_ack;
    logic core_req;
    irq_level_pkg::core_req_s core_sel;
    logic irq;
    logic accept_en = 1'b1;
    logic [3:0] ack_wait = 4'h0;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int k;
    logic [7:0] got_q[$];
    logic [15:0] idx_tab[5] = '{irq_level_pkg::IDX_TIMER8, irq_level_pkg::IDX_T16,
        irq_level_pkg::IDX_SERIAL, irq_level_pkg::IDX_SPI_I2C, irq_level_pkg::IDX_REMOTE};
    logic [31:0] wr_tab[5] = '{32'h0000_0006, 32'h0000_0701, 32'h0000_0502,
        32'h0000_0403, 32'h0000_0304};
    logic [31:0] lvl_tab[5] = '{32'h0000_0002, 32'h0000_0505, 32'h0000_0007,
        32'h0000_0000, 32'h0000_0305};
    logic [7:0] ord[7] = '{8'h13, 8'h11, 8'h12, 8'h17, 8'h18, 8'h10, 8'h15};

    interrupt_level_setup #(.VEC_BASE(8'h10)) interrupt_level_setup_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_pending(src_pending), .src_enable(src_enable), .core_ack(core_ack),
        .core_req(core_req), .core_sel(core_sel), .irq(irq));
    core_model core_model_i (.pclk(pclk), .presetn(presetn), .core_req(core_req),
        .core_sel(core_sel), .accept_en(accept_en), .ack_wait(ack_wait), .core_ack(core_ack));

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    // Flag logic clears the accepted source so it cannot request again
    always @(posedge pclk) begin
        if (core_ack === 1'b1) begin
            got_q.push_back(core_sel.vector);
            src_pending[core_sel.vector - 8'h10] <= 1'b0;
        end
    end

    task automatic results();
        $display("Summary: %0d checks, %0d mismatches", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Idle cycle after each transfer keeps psel from being driven twice in one step
    task automatic apb(input logic wr_n, input logic [15:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr_n;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle limit here: a slave that never answers runs into the bench timeout
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check(32'(n), 32'h2, "wait states");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rd, exp, "read data");
        check({31'h0, er}, 32'h0, "read error flag");
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] val);
        apb(1'b1, idx, val);
        check({31'h0, er}, 32'h0, "write error flag");
    endtask

    task automatic wait_acks(input int n);
        k = 0;
        while (got_q.size() < n && k < 300) begin
            @(posedge pclk);
            k++;
        end
        check(32'(got_q.size()), 32'(n), "accept count");
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (idx_tab[i]) rdc(idx_tab[i], 32'h0);
        rdc(irq_level_pkg::IDX_STATUS, 32'h0);
        rdc(irq_level_pkg::IDX_MASK, 32'h0);
        $display("reset value test done");
        foreach (idx_tab[i]) wr(idx_tab[i], wr_tab[i]);
        foreach (idx_tab[i]) rdc(idx_tab[i], wr_tab[i]);
        apb(1'b0, 16'h4320, 32'h0);
        check({31'h0, er}, 32'h1, "unmapped error flag");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, 16'h4320, 32'h0000_0707);
        check({31'h0, er}, 32'h1, "unmapped write error flag");
        $display("register test done");
        foreach (idx_tab[i]) wr(idx_tab[i], lvl_tab[i]);
        wr(irq_level_pkg::IDX_MASK, 32'h1);
        src_enable <= 9'h1AF;
        src_pending <= 9'h1FF;
        wait_acks(7);
        foreach (ord[i]) check({24'h0, got_q[i]}, {24'h0, ord[i]}, "order");
        repeat (5) @(posedge pclk);
        check({31'h0, core_req}, 32'h0, "disabled source kept back");
        check({31'h0, irq}, 32'h1, "irq on accept");
        rdc(irq_level_pkg::IDX_STATUS, 32'h1);
        wr(irq_level_pkg::IDX_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("priority test done");
        got_q.delete();
        wr(irq_level_pkg::IDX_MASK, 32'h2);
        accept_en <= 1'b0;
        ack_wait <= 4'h3;
        src_pending <= 9'h001;
        k = 0;
        while (core_req !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        check({21'h0, core_sel}, {21'h0, 8'h10, 3'h2}, "presented");
        repeat (5) @(posedge pclk);
        check({20'h0, core_req, core_sel}, {20'h0, 1'b1, 8'h10, 3'h2}, "held");
        src_pending[3] <= 1'b1;
        repeat (2) @(posedge pclk);
        check({20'h0, core_req, core_sel}, {20'h0, 1'b1, 8'h13, 3'h7}, "swapped");
        accept_en <= 1'b1;
        wait_acks(2);
        check({16'h0, got_q[0], got_q[1]}, 32'h0000_1310, "held request kept");
        check({31'h0, irq}, 32'h1, "irq on preempt");
        rdc(irq_level_pkg::IDX_STATUS, 32'h3);
        wr(irq_level_pkg::IDX_STATUS, 32'h3);
        check({31'h0, irq}, 32'h0, "irq cleared");
        $display("preempt test done");
        results();
    end
endmodule
